//--- core/lim_pkg.sv
// Constants and types for the local interrupt controller access logic
package lim_pkg;

  // ==========================================================
  // Modes
  typedef enum logic {
    LIM_LEGACY_MMIO_MODE  = 1'b0,
    LIM_EXTENDED_MSR_MODE = 1'b1
  } lim_mode_t;

  // ==========================================================
  // Widths
  localparam int unsigned LIM_DW         = 32;
  localparam int unsigned LIM_PAGE_AW    = 12;   // One 4 KB page
  localparam int unsigned LIM_MSR_IW     = 12;
  localparam int unsigned LIM_IDX_W      = 6;
  localparam int unsigned LIM_NREG       = 64;
  localparam int unsigned LIM_LEG_ID_W   = 8;
  localparam int unsigned LIM_EXT_ID_W   = 32;
  localparam int unsigned LIM_CLUSTER_W  = 16;
  localparam int unsigned LIM_MEMBER_W   = 16;
  localparam int unsigned LIM_MEMB_SEL_W = 4;

  // ==========================================================
  // Address map
  localparam int unsigned LIM_MMIO_STRIDE_LSB = 4;   // 16-byte register stride
  localparam logic [LIM_MSR_IW-1:0] LIM_MSR_BASE   = 12'h800;
  localparam logic [LIM_IDX_W-1:0]  LIM_IDX_ID     = 6'h02;
  localparam logic [LIM_IDX_W-1:0]  LIM_IDX_LDR    = 6'h0D;
  localparam int unsigned LIM_LEG_ID_LSB  = 24;
  localparam int unsigned LIM_LEG_LDR_LSB = 24;

  // ==========================================================
  // Reset values and special destinations
  localparam logic [LIM_DW-1:0]       LIM_REG_RST       = 32'h0000_0000;
  localparam logic [LIM_EXT_ID_W-1:0] LIM_PHYS_ID_RST   = 32'h0000_0000;
  localparam logic [LIM_LEG_ID_W-1:0] LIM_LEG_BCAST     = 8'hFF;
  localparam logic [LIM_EXT_ID_W-1:0] LIM_EXT_BCAST     = 32'hFFFF_FFFF;

endpackage : lim_pkg

//--- core/lim_dest_match.sv
// Destination identifier match for legacy and extended addressing
`timescale 1ns/1ps
module lim_dest_match
  import lim_pkg::*;
(
  input  wire lim_pkg::lim_mode_t         mode,
  input  wire logic [LIM_EXT_ID_W-1:0]    phys_id,
  input  wire logic [LIM_DW-1:0]          leg_ldr,
  input  wire logic [LIM_EXT_ID_W-1:0]    dest_id,
  input  wire logic                       dest_logical,
  output logic [LIM_DW-1:0]               ext_ldr,
  output logic                            hit
);
  import lim_pkg::*;

  logic [LIM_CLUSTER_W-1:0] own_cluster;
  logic [LIM_MEMBER_W-1:0]  own_member;
  logic [LIM_LEG_ID_W-1:0]  leg_id;

  // Logical id derived from physical id: cluster above, one-hot member below
  assign own_cluster = phys_id[LIM_MEMB_SEL_W +: LIM_CLUSTER_W];
  assign own_member  = LIM_MEMBER_W'(1) << phys_id[LIM_MEMB_SEL_W-1:0];
  assign ext_ldr     = {own_cluster, own_member};
  assign leg_id      = phys_id[LIM_LEG_ID_W-1:0];

  always_comb begin
    hit = 1'b0;
    case (mode)
      LIM_LEGACY_MMIO_MODE: begin
        if (dest_logical) begin
          hit = |(dest_id[LIM_LEG_ID_W-1:0] & leg_ldr[LIM_LEG_LDR_LSB +: LIM_LEG_ID_W]);
        end else begin
          hit = (dest_id[LIM_LEG_ID_W-1:0] == leg_id) ||
                (dest_id[LIM_LEG_ID_W-1:0] == LIM_LEG_BCAST);
        end
      end
      LIM_EXTENDED_MSR_MODE: begin
        if (dest_logical) begin
          hit = (dest_id[LIM_MEMBER_W +: LIM_CLUSTER_W] == own_cluster) &&
                (|(dest_id[LIM_MEMBER_W-1:0] & own_member));
        end else begin
          hit = (dest_id == phys_id) || (dest_id == LIM_EXT_BCAST);
        end
      end
      default: hit = 1'b0;
    endcase
  end

endmodule // lim_dest_match

//--- core/lim_access.sv
// Register access routing and identifier handling of the local interrupt controller
// Overview of operation
// - In legacy mode the registers answer on a memory-mapped 4 KB page window.
// - In extended mode the registers answer on the model-specific-register path.
// - In extended mode page-window accesses are refused and never reach a register.
// - The physical identifier is 8 bits in legacy mode and 32 bits in extended mode.
// - Extended physical destinations address up to 4G-1 processors, all ones broadcasts.
// - The extended logical identifier is a 16-bit cluster above a 16-bit member field.
// - Fewer than 32 physical identifier bits may be held if software cannot tell.
// - Cluster and member fields may be narrower than 16 bits if software cannot tell.
`timescale 1ns/1ps
module lim_access
  import lim_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic                       ext_mode_req,
  output lim_pkg::lim_mode_t              mode,
  input  wire logic                       mmio_valid,
  input  wire logic                       mmio_write,
  input  wire logic [LIM_PAGE_AW-1:0]     mmio_addr,
  input  wire logic [LIM_DW-1:0]          mmio_wdata,
  output logic                            mmio_ack,
  output logic                            mmio_err,
  output logic [LIM_DW-1:0]               mmio_rdata,
  input  wire logic                       msr_valid,
  input  wire logic                       msr_write,
  input  wire logic [LIM_MSR_IW-1:0]      msr_index,
  input  wire logic [LIM_DW-1:0]          msr_wdata,
  output logic                            msr_ack,
  output logic                            msr_err,
  output logic [LIM_DW-1:0]               msr_rdata,
  input  wire logic [LIM_EXT_ID_W-1:0]    dest_id,
  input  wire logic                       dest_logical,
  output logic                            dest_hit
);
  import lim_pkg::*;

  // ==========================================================
  // State
  lim_mode_t                mode_q;
  logic [LIM_DW-1:0]        regs_q [LIM_NREG];
  logic [LIM_EXT_ID_W-1:0]  phys_id_q;
  logic                     mmio_ack_q, mmio_err_q, msr_ack_q, msr_err_q;
  logic [LIM_DW-1:0]        mmio_rdata_q, msr_rdata_q;

  // ==========================================================
  // Decode
  logic                     mmio_ok, msr_ok, msr_in_range;
  logic [LIM_IDX_W-1:0]     mmio_idx, msr_idx, wr_idx;
  logic [LIM_MSR_IW-1:0]    msr_off;
  logic                     wr_en;
  logic [LIM_DW-1:0]        wr_data;
  logic [LIM_DW-1:0]        ext_ldr;

  assign mmio_idx     = mmio_addr[LIM_MMIO_STRIDE_LSB +: LIM_IDX_W];
  assign msr_off      = msr_index - LIM_MSR_BASE;
  assign msr_in_range = (msr_index >= LIM_MSR_BASE) &&
                        (msr_off < LIM_MSR_IW'(LIM_NREG));
  assign msr_idx      = msr_off[LIM_IDX_W-1:0];
  // Page window served only in legacy mode, 16-byte aligned addresses only
  assign mmio_ok      = mmio_valid && (mode_q == LIM_LEGACY_MMIO_MODE) &&
                        (mmio_addr[LIM_MMIO_STRIDE_LSB-1:0] == '0);
  assign msr_ok       = msr_valid && (mode_q == LIM_EXTENDED_MSR_MODE) &&
                        msr_in_range;

  // Only the path of the current mode may write
  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = '0;
    wr_data = '0;
    if (mmio_ok && mmio_write) begin
      wr_en   = 1'b1;
      wr_idx  = mmio_idx;
      wr_data = mmio_wdata;
    end else if (msr_ok && msr_write) begin
      wr_en   = 1'b1;
      wr_idx  = msr_idx;
      wr_data = msr_wdata;
    end
  end

  // ==========================================================
  // Mode select: leaves legacy mode only on request, back only by reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= LIM_LEGACY_MMIO_MODE;
    end else if (ext_mode_req) begin
      mode_q <= LIM_EXTENDED_MSR_MODE;
    end
  end
  assign mode = mode_q;

  // ==========================================================
  // Physical identifier: 8 bits writable in legacy mode, read-only in extended
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phys_id_q <= LIM_PHYS_ID_RST;
    end else if (wr_en && (wr_idx == LIM_IDX_ID) && (mode_q == LIM_LEGACY_MMIO_MODE)) begin
      phys_id_q <= {{(LIM_EXT_ID_W-LIM_LEG_ID_W){1'b0}},
                    wr_data[LIM_LEG_ID_LSB +: LIM_LEG_ID_W]};
    end
  end

  // ==========================================================
  // Generic register array
  generate
    for (genvar i = 0; i < LIM_NREG; i++) begin : g_reg
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          regs_q[i] <= LIM_REG_RST;
        end else if (wr_en && (wr_idx == LIM_IDX_W'(i)) && (LIM_IDX_W'(i) != LIM_IDX_ID) &&
                     !((LIM_IDX_W'(i) == LIM_IDX_LDR) &&
                       (mode_q == LIM_EXTENDED_MSR_MODE))) begin
          regs_q[i] <= wr_data;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read views
  function automatic logic [LIM_DW-1:0] rd_view(input logic [LIM_IDX_W-1:0] idx,
                                                input lim_mode_t md);
    logic [LIM_DW-1:0] v;
    v = regs_q[idx];
    if (idx == LIM_IDX_ID) begin
      v = (md == LIM_EXTENDED_MSR_MODE) ? phys_id_q :
          {phys_id_q[LIM_LEG_ID_W-1:0], {(LIM_DW-LIM_LEG_ID_W){1'b0}}};
    end else if ((idx == LIM_IDX_LDR) && (md == LIM_EXTENDED_MSR_MODE)) begin
      v = ext_ldr;
    end
    return v;
  endfunction

  // ==========================================================
  // Page window answer, one cycle after the request
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mmio_ack_q   <= 1'b0;
      mmio_err_q   <= 1'b0;
      mmio_rdata_q <= '0;
    end else begin
      mmio_ack_q   <= mmio_valid;
      mmio_err_q   <= mmio_valid && !mmio_ok;
      mmio_rdata_q <= (mmio_ok && !mmio_write) ? rd_view(mmio_idx, mode_q) : '0;
    end
  end

  // Model-specific-register answer, one cycle after the request
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      msr_ack_q   <= 1'b0;
      msr_err_q   <= 1'b0;
      msr_rdata_q <= '0;
    end else begin
      msr_ack_q   <= msr_valid;
      msr_err_q   <= msr_valid && !msr_ok;
      msr_rdata_q <= (msr_ok && !msr_write) ? rd_view(msr_idx, mode_q) : '0;
    end
  end

  assign mmio_ack   = mmio_ack_q;
  assign mmio_err   = mmio_err_q;
  assign mmio_rdata = mmio_rdata_q;
  assign msr_ack    = msr_ack_q;
  assign msr_err    = msr_err_q;
  assign msr_rdata  = msr_rdata_q;

  // ==========================================================
  // Destination match
  lim_dest_match u_match (
    .mode         (mode_q),
    .phys_id      (phys_id_q),
    .leg_ldr      (regs_q[LIM_IDX_LDR]),
    .dest_id      (dest_id),
    .dest_logical (dest_logical),
    .ext_ldr      (ext_ldr),
    .hit          (dest_hit)
  );

  // ==========================================================
  // Assertions
  a_mmio_refused: assert property (@(posedge mclk) disable iff (!nrst)
    mmio_valid && (mode_q == LIM_EXTENDED_MSR_MODE) |=> mmio_ack && mmio_err)
    else $error("page access not refused in extended mode");
  a_msr_refused: assert property (@(posedge mclk) disable iff (!nrst)
    msr_valid && (mode_q == LIM_LEGACY_MMIO_MODE) |=> msr_ack && msr_err)
    else $error("register path access not refused in legacy mode");
  a_mmio_nowrite: assert property (@(posedge mclk) disable iff (!nrst)
    mmio_valid && mmio_write && !msr_valid && (mode_q == LIM_EXTENDED_MSR_MODE)
    |-> !wr_en)
    else $error("refused page write changed a register");
  a_mode_sticky: assert property (@(posedge mclk) disable iff (!nrst)
    mode_q == LIM_EXTENDED_MSR_MODE |=> mode_q == LIM_EXTENDED_MSR_MODE)
    else $error("extended mode left without reset");
  a_mode_enter: assert property (@(posedge mclk) disable iff (!nrst)
    ext_mode_req |=> mode == LIM_EXTENDED_MSR_MODE)
    else $error("mode request not taken");
  a_msr_readback: assert property (@(posedge mclk) disable iff (!nrst)
    msr_ok && msr_write && (msr_idx == 6'h10) ##1 !(wr_en && (wr_idx == 6'h10)) ##1
    msr_ok && !msr_write && !mmio_ok && (msr_idx == 6'h10)
    |=> msr_rdata == $past(msr_wdata, 3))
    else $error("register path read does not return written word");
  a_mmio_readback: assert property (@(posedge mclk) disable iff (!nrst)
    mmio_ok && mmio_write && (mmio_idx == 6'h10) ##1 !(wr_en && (wr_idx == 6'h10)) ##1
    mmio_ok && !mmio_write && (mmio_idx == 6'h10)
    |=> mmio_rdata == $past(mmio_wdata, 3))
    else $error("page read does not return written word");
  a_ext_id_wide: assert property (@(posedge mclk) disable iff (!nrst)
    msr_ok && !msr_write && (msr_idx == LIM_IDX_ID) |=> msr_rdata == phys_id_q)
    else $error("extended identifier read wrong");
  a_leg_id_narrow: assert property (@(posedge mclk) disable iff (!nrst)
    mmio_ok && !mmio_write && (mmio_idx == LIM_IDX_ID)
    |=> mmio_rdata[LIM_LEG_ID_LSB-1:0] == '0)
    else $error("legacy identifier read wider than 8 bits");
  a_ext_bcast: assert property (@(posedge mclk) disable iff (!nrst)
    (mode_q == LIM_EXTENDED_MSR_MODE) && !dest_logical && (dest_id == LIM_EXT_BCAST)
    |-> dest_hit)
    else $error("extended broadcast missed");
  a_ext_cluster: assert property (@(posedge mclk) disable iff (!nrst)
    (mode_q == LIM_EXTENDED_MSR_MODE) && dest_logical &&
    (dest_id[31:16] != phys_id_q[19:4]) |-> !dest_hit)
    else $error("logical hit outside own cluster");

  c_mode_switch: cover property (@(posedge mclk) disable iff (!nrst)
    ext_mode_req && (mode_q == LIM_LEGACY_MMIO_MODE));
  c_msr_read: cover property (@(posedge mclk) disable iff (!nrst) msr_ok && !msr_write);
  c_mmio_refused: cover property (@(posedge mclk) disable iff (!nrst)
    mmio_valid && (mode_q == LIM_EXTENDED_MSR_MODE));
  c_logical_hit: cover property (@(posedge mclk) disable iff (!nrst)
    dest_logical && dest_hit && (mode_q == LIM_EXTENDED_MSR_MODE));

endmodule // lim_access

//--- dv/lim_core_model.sv
// Processor core model issuing page-window and register-path accesses
`timescale 1ns/1ps
module lim_core_model (
  input  wire logic                           mclk,
  output logic                                ext_mode_req,
  output logic                                mmio_valid,
  output logic                                mmio_write,
  output logic [lim_pkg::LIM_PAGE_AW-1:0]     mmio_addr,
  output logic [lim_pkg::LIM_DW-1:0]          mmio_wdata,
  input  wire logic                           mmio_ack,
  input  wire logic                           mmio_err,
  input  wire logic [lim_pkg::LIM_DW-1:0]     mmio_rdata,
  output logic                                msr_valid,
  output logic                                msr_write,
  output logic [lim_pkg::LIM_MSR_IW-1:0]      msr_index,
  output logic [lim_pkg::LIM_DW-1:0]          msr_wdata,
  input  wire logic                           msr_ack,
  input  wire logic                           msr_err,
  input  wire logic [lim_pkg::LIM_DW-1:0]     msr_rdata
);
  import lim_pkg::*;

  // ==========================================================
  // Idle state
  initial begin
    ext_mode_req = 1'b0;
    mmio_valid = 1'b0;
    mmio_write = 1'b0;
    mmio_addr = '0;
    mmio_wdata = '0;
    msr_valid = 1'b0;
    msr_write = 1'b0;
    msr_index = '0;
    msr_wdata = '0;
  end

  // ==========================================================
  // Mode switch before any extended use
  task automatic enter_ext();
    @(posedge mclk);
    #1 ext_mode_req = 1'b1;
    @(posedge mclk);
    #1 ext_mode_req = 1'b0;
  endtask

  // ==========================================================
  // One access; path 1 is the register path
  task automatic acc(input logic path, input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic ack, output logic err,
                     output logic [31:0] rd);
    @(posedge mclk);
    #1;
    if (path) begin
      msr_valid = 1'b1;
      msr_write = wr;
      msr_index = a;
      msr_wdata = d;
    end else begin
      mmio_valid = 1'b1;
      mmio_write = wr;
      mmio_addr = a;
      mmio_wdata = d;
    end
    @(posedge mclk);
    #1;
    ack = path ? msr_ack : mmio_ack;
    err = path ? msr_err : mmio_err;
    rd = path ? msr_rdata : mmio_rdata;
    mmio_valid = 1'b0;
    msr_valid = 1'b0;
    // Released lines do not keep the last value
    mmio_addr = ~mmio_addr;
    mmio_wdata = ~mmio_wdata;
    msr_index = ~msr_index;
    msr_wdata = ~msr_wdata;
  endtask
endmodule // lim_core_model

//--- dv/lim_access_test.sv
// Self-checking testbench for the controller access logic
`timescale 1ns/1ps
module lim_access_test;
  import lim_pkg::*;

  logic                   mclk;
  logic                   nrst;
  logic                   ext_mode_req;
  lim_mode_t              mode;
  logic                   mmio_valid;
  logic                   mmio_write;
  logic [LIM_PAGE_AW-1:0] mmio_addr;
  logic [LIM_DW-1:0]      mmio_wdata;
  logic                   mmio_ack;
  logic                   mmio_err;
  logic [LIM_DW-1:0]      mmio_rdata;
  logic                   msr_valid;
  logic                   msr_write;
  logic [LIM_MSR_IW-1:0]  msr_index;
  logic [LIM_DW-1:0]      msr_wdata;
  logic                   msr_ack;
  logic                   msr_err;
  logic [LIM_DW-1:0]      msr_rdata;
  logic [LIM_EXT_ID_W-1:0] dest_id;
  logic                   dest_logical;
  logic                   dest_hit;
  int                     n_fail;
  int                     check_count;

  lim_access u_lim_access (.mclk(mclk), .nrst(nrst), .ext_mode_req(ext_mode_req),
    .mode(mode), .mmio_valid(mmio_valid), .mmio_write(mmio_write),
    .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata), .mmio_ack(mmio_ack),
    .mmio_err(mmio_err), .mmio_rdata(mmio_rdata), .msr_valid(msr_valid),
    .msr_write(msr_write), .msr_index(msr_index), .msr_wdata(msr_wdata),
    .msr_ack(msr_ack), .msr_err(msr_err), .msr_rdata(msr_rdata),
    .dest_id(dest_id), .dest_logical(dest_logical), .dest_hit(dest_hit));

  lim_core_model u_lim_core_model (.mclk(mclk), .ext_mode_req(ext_mode_req),
    .mmio_valid(mmio_valid), .mmio_write(mmio_write), .mmio_addr(mmio_addr),
    .mmio_wdata(mmio_wdata), .mmio_ack(mmio_ack), .mmio_err(mmio_err),
    .mmio_rdata(mmio_rdata), .msr_valid(msr_valid), .msr_write(msr_write),
    .msr_index(msr_index), .msr_wdata(msr_wdata), .msr_ack(msr_ack),
    .msr_err(msr_err), .msr_rdata(msr_rdata));

  // ==========================================================
  // Compare and access helpers
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %b seen %b", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic xfer(input logic p, input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic e_err, input logic [31:0] e_rd);
    logic ack;
    logic err;
    logic [31:0] rd;
    u_lim_core_model.acc(p, wr, a, d, ack, err, rd);
    chk1("ack", 1'b1, ack);
    chk1("err", e_err, err);
    chk32("rdata", e_rd, rd);
  endtask

  task automatic dchk(input logic lg, input logic [31:0] id, input logic e);
    @(posedge mclk);
    #1;
    dest_logical = lg;
    dest_id = id;
    #1 chk1("dest_hit", e, dest_hit);
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_legacy_page();
    chk1("mode", 1'b0, mode);
    xfer(0, 0, 12'h100, 32'h0, 0, 32'h0);
    xfer(0, 1, 12'h100, 32'hA5A5_0001, 0, 32'h0);
    xfer(0, 0, 12'hD00, 32'h0, 0, 32'hA5A5_0001);
    xfer(0, 1, 12'h3F0, 32'h1234_5678, 0, 32'h0);
    xfer(0, 0, 12'h3F0, 32'h0, 0, 32'h1234_5678);
    xfer(0, 1, 12'h104, 32'hFFFF_FFFF, 1, 32'h0);
    xfer(1, 1, 12'h810, 32'h0BAD_0BAD, 1, 32'h0);
    xfer(1, 0, 12'h810, 32'h0, 1, 32'h0);
    xfer(0, 0, 12'h100, 32'h0, 0, 32'hA5A5_0001);
  endtask

  task automatic test_legacy_id();
    xfer(0, 1, 12'h020, 32'hAB00_0000, 0, 32'h0);
    xfer(0, 0, 12'h020, 32'h0, 0, 32'hAB00_0000);
    dchk(0, 32'h0000_00AB, 1);
    dchk(0, 32'h0000_00AC, 0);
    dchk(0, 32'h0000_00FF, 1);
    xfer(0, 1, 12'h0D0, 32'h0400_0000, 0, 32'h0);
    dchk(1, 32'h0000_0004, 1);
    dchk(1, 32'h0000_0008, 0);
  endtask

  task automatic test_ext_path();
    u_lim_core_model.enter_ext();
    chk1("mode", 1'b1, mode);
    xfer(0, 1, 12'h100, 32'hFFFF_FFFF, 1, 32'h0);
    xfer(0, 0, 12'h100, 32'h0, 1, 32'h0);
    xfer(1, 0, 12'h810, 32'h0, 0, 32'hA5A5_0001);
    xfer(1, 1, 12'h810, 32'hCAFE_F00D, 0, 32'h0);
    xfer(1, 0, 12'h810, 32'h0, 0, 32'hCAFE_F00D);
    xfer(1, 0, 12'h83F, 32'h0, 0, 32'h1234_5678);
    xfer(1, 0, 12'h840, 32'h0, 1, 32'h0);
    xfer(1, 1, 12'h7FF, 32'h0, 1, 32'h0);
    chk1("mode", 1'b1, mode);
  endtask

  task automatic test_ext_id();
    xfer(1, 0, 12'h802, 32'h0, 0, 32'h0000_00AB);
    xfer(1, 1, 12'h802, 32'h1234_0000, 0, 32'h0);
    xfer(1, 0, 12'h802, 32'h0, 0, 32'h0000_00AB);
    dchk(0, 32'h0000_00AB, 1);
    dchk(0, 32'h0100_00AB, 0);
    dchk(0, 32'hFFFF_FFFF, 1);
    xfer(1, 0, 12'h80D, 32'h0, 0, 32'h000A_0800);
    dchk(1, 32'h000A_0800, 1);
    dchk(1, 32'h000B_0800, 0);
    dchk(1, 32'h000A_0400, 0);
  endtask

  task automatic test_rereset();
    @(posedge mclk);
    #1 nrst = 1'b0;
    repeat (12) @(posedge mclk);
    #1 nrst = 1'b1;
    chk1("mode", 1'b0, mode);
    xfer(0, 0, 12'h100, 32'h0, 0, 32'h0);
    xfer(0, 0, 12'h020, 32'h0, 0, 32'h0);
  endtask

  // ==========================================================
  // Clock, run control and verdict
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    dest_id = '0;
    dest_logical = 1'b0;
    nrst = 1'b0;
    repeat (12) @(posedge mclk);
    #1 nrst = 1'b1;
    test_legacy_page();
    test_legacy_id();
    test_ext_path();
    test_ext_id();
    test_rereset();
    end_sim();
  end
endmodule // lim_access_test
